/* File: common/pps_pkg.sv */
// Purpose: Shared constants and types for the port pin control block.
// Assumes: One 8-bit port, registers on a 32-bit classic Wishbone bus.
// Notes:   Each register holds one aligned word; unused upper bits read zero.
`default_nettype none
package pps_pkg;
    localparam int          PPS_WIDTH              = 8;
    // Byte addresses of the registers.
    localparam logic [7:0]  PPS_ADR_INPUT_SAMPLE   = 8'h00;
    localparam logic [7:0]  PPS_ADR_DIRECTION      = 8'h04;
    localparam logic [7:0]  PPS_ADR_DRIVE          = 8'h08;
    localparam logic [7:0]  PPS_ADR_MCU_CONTROL    = 8'h0c;
    localparam logic [7:0]  PPS_ADR_SLEEP_CONTROL  = 8'h10;
    localparam logic [7:0]  PPS_ADR_EXT_ENABLE     = 8'h14;
    localparam logic [7:0]  PPS_ADR_EXT_SENSE      = 8'h18;
    localparam logic [7:0]  PPS_ADR_EXT_FLAG       = 8'h1c;
    // Field positions.
    localparam int          PPS_PULLUP_OFF_BIT     = 4;
    localparam int          PPS_SLEEP_MODE_LSB     = 0;
    localparam int          PPS_SLEEP_ASLEEP_BIT   = 7;
    // Reset values and default interrupt-capable pins.
    localparam logic [7:0]  PPS_RST_BYTE           = 8'h00;
    localparam logic [15:0] PPS_RST_SENSE          = 16'h0000;
    localparam logic [7:0]  PPS_EXT_CAPABLE_PINS   = 8'h03;

    typedef enum logic [1:0]
    {
        PPS_PIN_HIZ      = 2'h0,
        PPS_PIN_PULLUP   = 2'h1,
        PPS_PIN_OUT_HIGH = 2'h3,
        PPS_PIN_OUT_LOW  = 2'h2
    } pps_pin_state_type;

    typedef enum logic [2:0]
    {
        PPS_SLEEP_IDLE       = 3'h0,
        PPS_SLEEP_POWER_DOWN = 3'h2,
        PPS_SLEEP_POWER_SAVE = 3'h3,
        PPS_SLEEP_STANDBY    = 3'h6
    } pps_sleep_mode_type;

    typedef enum logic [1:0]
    {
        PPS_SENSE_LOW_LEVEL  = 2'h0,
        PPS_SENSE_ANY_CHANGE = 2'h1,
        PPS_SENSE_FALLING    = 2'h2,
        PPS_SENSE_RISING     = 2'h3
    } pps_sense_type;
endpackage
`default_nettype wire

/* File: verilog/pps_port_sync.sv */
// Purpose: Input synchronizer of the port: falling-edge latch, then rising-edge register.
// Assumes: d_i may change at any time relative to clk_i.
// Notes:   The latch stage is read only by the output register.
`default_nettype none
module pps_port_sync
    import pps_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic [PPS_WIDTH-1:0] d_i,
    output logic      [PPS_WIDTH-1:0] q_o
);
    logic [PPS_WIDTH-1:0] lat_r;
    logic [PPS_WIDTH-1:0] q_r;

    // The latch closes on the falling edge, holding the pad level.
    always_ff @(negedge clk_i)
    begin
        lat_r <= rst_i ? PPS_RST_BYTE : d_i;
    end

    always_ff @(posedge clk_i)
    begin
        q_r <= rst_i ? PPS_RST_BYTE : lat_r;
    end

    assign q_o = q_r;

    a_sync_capture: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> q_r == $past(lat_r))
        else $error("sample register did not take the latched pad value");
endmodule
`default_nettype wire

/* File: verilog/pps_pin_decode.sv */
// Purpose: Maps direction, drive and pull-up disable onto pad controls per pin.
// Assumes: rst_i may be asserted while no clock runs.
// Notes:   Reset forces the pads to high impedance without waiting for a clock edge.
`default_nettype none
module pps_pin_decode
    import pps_pkg::*;
(
    input  wire logic [PPS_WIDTH-1:0] dir_i,
    input  wire logic [PPS_WIDTH-1:0] drive_i,
    input  wire logic                 pullup_off_i,
    input  wire logic                 rst_i,
    output logic      [PPS_WIDTH-1:0] oe_o,
    output logic      [PPS_WIDTH-1:0] pullup_o
);
    pps_pin_state_type st;

    always_comb
    begin
        oe_o     = '0;
        pullup_o = '0;
        st       = PPS_PIN_HIZ;
        for (int n = 0; n < PPS_WIDTH; n++)
        begin
            st = pps_pin_state_type'({dir_i[n], drive_i[n]});
            case (st)
                PPS_PIN_HIZ:      oe_o[n] = 1'b0;
                PPS_PIN_PULLUP:   pullup_o[n] = ~pullup_off_i & ~rst_i;
                PPS_PIN_OUT_LOW:  oe_o[n] = ~rst_i;
                PPS_PIN_OUT_HIGH: oe_o[n] = ~rst_i;
                default:          oe_o[n] = 1'b0;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: verilog/pps_port_pin_control.sv */
// Purpose: One 8-bit general-purpose port with Wishbone registers, sync and sleep clamp.
// Assumes: Classic Wishbone single cycles; pad_i is asynchronous to clk_i.
// Notes:   pad_o drives the pad level only while pad_oe_o is high.
// How it works
// - Direction and drive bits pick high-Z, pull-up, output low or output high.
// - Global pull-up off turns pull-up settings into plain high-Z inputs.
// - The sampled pad value is readable whatever the direction bit.
// - Pad passes a falling-edge latch, then a rising-edge register.
// - External pad changes show in the sample after half to one and a half cycles.
// - A written drive value shows in the sample half a cycle after the latch.
// - Deep sleep modes clamp digital inputs to ground.
// - Interrupt-capable pins enabled as external interrupts escape the clamp; all other pins do not.
// - Clamp release on a disabled interrupt-capable high pin sensed for rising or any change sets its flag on wake.
// - Inputs stay unclamped in reset, active and idle.
// - Pull-ups are off while reset is held.
// - Writing one to a sample bit inverts its drive bit; zero does nothing.
// - All pads go high impedance as soon as reset rises, clock or not.
// - Pull-up off lives in bit 4 of the control register, read and write.
//
// Design decisions made here: register access over Wishbone and the address map.
`default_nettype none
module pps_port_pin_control
    import pps_pkg::*;
#(
    parameter logic [PPS_WIDTH-1:0] EXT_CAPABLE = PPS_EXT_CAPABLE_PINS
)
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    input  wire logic [PPS_WIDTH-1:0] pad_i,
    output logic      [PPS_WIDTH-1:0] pad_o,
    output logic      [PPS_WIDTH-1:0] pad_oe_o,
    output logic      [PPS_WIDTH-1:0] pullup_en_o,
    input  wire logic                 wake_i,
    output logic      [PPS_WIDTH-1:0] ext_flag_o
);
    function automatic logic is_deep_sleep(input logic [2:0] mode);
        is_deep_sleep = (mode == PPS_SLEEP_POWER_DOWN) ||
                        (mode == PPS_SLEEP_POWER_SAVE) ||
                        (mode == PPS_SLEEP_STANDBY);
    endfunction

    logic                 ack_r;
    logic [31:0]          dat_r;
    logic [PPS_WIDTH-1:0] dir_r;
    logic [PPS_WIDTH-1:0] dir_nxt;
    logic [PPS_WIDTH-1:0] drive_r;
    logic [PPS_WIDTH-1:0] drive_nxt;
    logic                 pullup_off_r;
    logic                 pullup_off_nxt;
    logic [2:0]           sleep_mode_r;
    logic [2:0]           sleep_mode_nxt;
    logic                 asleep_r;
    logic                 asleep_nxt;
    logic [PPS_WIDTH-1:0] ext_en_r;
    logic [PPS_WIDTH-1:0] ext_en_nxt;
    logic [15:0]          sense_r;
    logic [15:0]          sense_nxt;
    logic [PPS_WIDTH-1:0] flag_r;
    logic [PPS_WIDTH-1:0] flag_nxt;
    logic [PPS_WIDTH-1:0] prev_r;
    logic [PPS_WIDTH-1:0] sample_w;
    logic [PPS_WIDTH-1:0] set_w;

    // Bus decode.
    wire                  req_w      = wb_cyc_i & wb_stb_i;
    wire                  wr_cyc_w   = req_w & wb_we_i & ack_r;
    wire                  lane0_w    = wr_cyc_w & wb_sel_i[0];
    wire                  lane1_w    = wr_cyc_w & wb_sel_i[1];
    wire                  hit_in_w   = wb_adr_i == PPS_ADR_INPUT_SAMPLE;
    wire                  hit_dir_w  = wb_adr_i == PPS_ADR_DIRECTION;
    wire                  hit_drv_w  = wb_adr_i == PPS_ADR_DRIVE;
    wire                  hit_mcu_w  = wb_adr_i == PPS_ADR_MCU_CONTROL;
    wire                  hit_slp_w  = wb_adr_i == PPS_ADR_SLEEP_CONTROL;
    wire                  hit_en_w   = wb_adr_i == PPS_ADR_EXT_ENABLE;
    wire                  hit_sns_w  = wb_adr_i == PPS_ADR_EXT_SENSE;
    wire                  hit_flg_w  = wb_adr_i == PPS_ADR_EXT_FLAG;
    wire [7:0]            wbyte_w    = wb_dat_i[7:0];

    // Read selection; unmapped addresses read as zero.
    wire [7:0]  mcu_rd_w  = {3'h0, pullup_off_r, 4'h0};
    wire [7:0]  slp_rd_w  = {asleep_r, 4'h0, sleep_mode_r};
    wire [31:0] rd_word_w = hit_in_w  ? {24'h0, sample_w} :
                            hit_dir_w ? {24'h0, dir_r} :
                            hit_drv_w ? {24'h0, drive_r} :
                            hit_mcu_w ? {24'h0, mcu_rd_w} :
                            hit_slp_w ? {24'h0, slp_rd_w} :
                            hit_en_w  ? {24'h0, ext_en_r} :
                            hit_sns_w ? {16'h0, sense_r} :
                            hit_flg_w ? {24'h0, flag_r} : 32'h0;

    // Register next values.
    assign dir_nxt        = (lane0_w && hit_dir_w) ? wbyte_w : dir_r;
    assign drive_nxt      = (lane0_w && hit_drv_w) ? wbyte_w :
                            (lane0_w && hit_in_w) ? (drive_r ^ wbyte_w) : drive_r;
    assign pullup_off_nxt = (lane0_w && hit_mcu_w) ? wbyte_w[PPS_PULLUP_OFF_BIT]
                                                   : pullup_off_r;
    assign sleep_mode_nxt = (lane0_w && hit_slp_w) ? wbyte_w[PPS_SLEEP_MODE_LSB +: 3]
                                                   : sleep_mode_r;
    assign asleep_nxt     = (lane0_w && hit_slp_w) ? wbyte_w[PPS_SLEEP_ASLEEP_BIT]
                                                   : (asleep_r & ~wake_i);
    assign ext_en_nxt     = (lane0_w && hit_en_w) ? wbyte_w : ext_en_r;
    assign sense_nxt      = {(lane1_w && hit_sns_w) ? wb_dat_i[15:8] : sense_r[15:8],
                             (lane0_w && hit_sns_w) ? wbyte_w : sense_r[7:0]};
    // Hardware set wins over a software write-one clear in the same cycle.
    assign flag_nxt       = (flag_r & ~((lane0_w && hit_flg_w) ? wbyte_w : 8'h00)) | set_w;

    // Sleep clamp ahead of the synchronizer.
    wire                  deep_w  = asleep_r & is_deep_sleep(sleep_mode_r) & ~rst_i;
    wire [PPS_WIDTH-1:0]  clamp_w = {PPS_WIDTH{deep_w}} & ~(EXT_CAPABLE & ext_en_r);
    wire [PPS_WIDTH-1:0]  din_w   = pad_i & ~clamp_w;
    wire [PPS_WIDTH-1:0]  rise_w  = sample_w & ~prev_r;
    wire [PPS_WIDTH-1:0]  fall_w  = ~sample_w & prev_r;

    pps_port_sync u_sync
    (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (din_w),
        .q_o   (sample_w)
    );

    pps_pin_decode u_decode
    (
        .dir_i        (dir_r),
        .drive_i      (drive_r),
        .pullup_off_i (pullup_off_r),
        .rst_i        (rst_i),
        .oe_o         (pad_oe_o),
        .pullup_o     (pullup_en_o)
    );

    // Flags of interrupt-capable pins follow edges of the clamped sample, enabled or not.
    always_comb
    begin
        set_w = '0;
        for (int n = 0; n < PPS_WIDTH; n++)
        begin
            case (pps_sense_type'(sense_r[2*n +: 2]))
                PPS_SENSE_ANY_CHANGE: set_w[n] = rise_w[n] | fall_w[n];
                PPS_SENSE_FALLING:    set_w[n] = fall_w[n];
                PPS_SENSE_RISING:     set_w[n] = rise_w[n];
                default:              set_w[n] = 1'b0;
            endcase
        end
        set_w = set_w & EXT_CAPABLE;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_r <= 1'b0;
            dat_r <= 32'h0;
        end
        else
        begin
            ack_r <= req_w & ~ack_r;
            dat_r <= (req_w & ~ack_r) ? rd_word_w : dat_r;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dir_r        <= PPS_RST_BYTE;
            drive_r      <= PPS_RST_BYTE;
            pullup_off_r <= 1'b0;
            sleep_mode_r <= PPS_SLEEP_IDLE;
            asleep_r     <= 1'b0;
        end
        else
        begin
            dir_r        <= dir_nxt;
            drive_r      <= drive_nxt;
            pullup_off_r <= pullup_off_nxt;
            sleep_mode_r <= sleep_mode_nxt;
            asleep_r     <= asleep_nxt;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ext_en_r <= PPS_RST_BYTE;
            sense_r  <= PPS_RST_SENSE;
            flag_r   <= PPS_RST_BYTE;
            prev_r   <= PPS_RST_BYTE;
        end
        else
        begin
            ext_en_r <= ext_en_nxt;
            sense_r  <= sense_nxt;
            flag_r   <= flag_nxt;
            prev_r   <= sample_w;
        end
    end

    assign wb_ack_o   = ack_r;
    assign wb_dat_o   = dat_r;
    assign pad_o      = drive_r;
    assign ext_flag_o = flag_r;

    sequence s_write_lane0(logic [7:0] adr);
        wb_cyc_i && wb_stb_i && wb_we_i && ack_r && wb_sel_i[0] && wb_adr_i == adr;
    endsequence

    a_pin_out_high: assert property (@(posedge clk_i) disable iff (rst_i)
        dir_r[0] && drive_r[0] |-> pad_oe_o[0] && pad_o[0] && !pullup_en_o[0])
        else $error("output high setting does not drive the pad high");
    a_pin_pullup_on: assert property (@(posedge clk_i) disable iff (rst_i)
        !dir_r[0] && drive_r[0] && !pullup_off_r |-> !pad_oe_o[0] && pullup_en_o[0])
        else $error("pull-up setting does not enable the pull-up");
    a_pullup_off_all: assert property (@(posedge clk_i) disable iff (rst_i)
        pullup_off_r |-> pullup_en_o == 8'h00 && (pad_oe_o & ~dir_r) == 8'h00)
        else $error("pull-up active while pull-up off is set");
    a_reset_tristate: assert property (@(posedge clk_i)
        rst_i |-> pad_oe_o == 8'h00 && pullup_en_o == 8'h00)
        else $error("pad driven or pulled up during reset");
    a_toggle_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        s_write_lane0(PPS_ADR_INPUT_SAMPLE) |=> drive_r == ($past(drive_r) ^ $past(wbyte_w)))
        else $error("write to sample register did not toggle drive bits");
    a_pullup_off_rw: assert property (@(posedge clk_i) disable iff (rst_i)
        s_write_lane0(PPS_ADR_MCU_CONTROL) |=>
        pullup_off_r == $past(wbyte_w[PPS_PULLUP_OFF_BIT]))
        else $error("pull-up off bit did not take the written value");
    a_clamp_deep: assert property (@(posedge clk_i) disable iff (rst_i)
        asleep_r && is_deep_sleep(sleep_mode_r) |->
        clamp_w == ~(EXT_CAPABLE & ext_en_r))
        else $error("deep sleep clamp wrong for some pin");
    a_clamp_awake: assert property (@(posedge clk_i)
        rst_i || !asleep_r || sleep_mode_r == PPS_SLEEP_IDLE |-> clamp_w == 8'h00)
        else $error("input clamped outside deep sleep");
    a_flag_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
        set_w != 8'h00 |=> (flag_r & $past(set_w)) == $past(set_w))
        else $error("edge on a sensed pin did not set its flag");
    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        req_w && !ack_r |=> ack_r ##1 !ack_r)
        else $error("bus acknowledge not a single cycle after the request");

    sequence s_read_capture(logic [7:0] adr);
        wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r && wb_adr_i == adr;
    endsequence

    // Two quiet edges with an unchanged pad level let that level through both stages.
    sequence s_pad_held;
        !rst_i && $stable(din_w) ##1 !rst_i && $stable(din_w);
    endsequence

    // Pad settings of pin 0 stand for every pin of the port.
    a_pin_out_low: assert property (@(posedge clk_i) disable iff (rst_i)
        dir_r[0] && !drive_r[0] |-> pad_oe_o[0] && !pad_o[0] && !pullup_en_o[0])
        else $error("output low setting does not drive the pad low");
    a_pin_hiz: assert property (@(posedge clk_i) disable iff (rst_i)
        !dir_r[0] && !drive_r[0] |-> !pad_oe_o[0] && !pullup_en_o[0])
        else $error("high impedance setting drives or pulls the pad");
    a_dir_write: assert property (@(posedge clk_i) disable iff (rst_i)
        s_write_lane0(PPS_ADR_DIRECTION) |=> dir_r == $past(wbyte_w))
        else $error("direction register did not take the written value");
    a_sample_read: assert property (@(posedge clk_i) disable iff (rst_i)
        s_read_capture(PPS_ADR_INPUT_SAMPLE) |=> wb_dat_o == {24'h0, $past(sample_w)})
        else $error("sample register read did not return the sampled pads");
    a_sync_latency: assert property (@(posedge clk_i) disable iff (rst_i)
        s_pad_held |-> sample_w == din_w)
        else $error("steady pad level missing from the sample one cycle on");
    a_toggle_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        s_write_lane0(PPS_ADR_INPUT_SAMPLE) ##0 wbyte_w == 8'h00 |=> $stable(drive_r))
        else $error("writing zero to the sample register changed drive bits");

    // Sleep clamp, its exemptions, wake from sleep and write-one clearing of flags.
    a_clamp_ground: assert property (@(posedge clk_i) disable iff (rst_i)
        asleep_r && is_deep_sleep(sleep_mode_r) |->
        (din_w & ~(EXT_CAPABLE & ext_en_r)) == 8'h00)
        else $error("clamped pin fed a high level into the synchronizer");
    a_exempt_pass: assert property (@(posedge clk_i) disable iff (rst_i)
        asleep_r && is_deep_sleep(sleep_mode_r) |->
        (din_w & EXT_CAPABLE & ext_en_r) == (pad_i & EXT_CAPABLE & ext_en_r))
        else $error("enabled interrupt pin was clamped in deep sleep");
    a_reset_unclamped: assert property (@(posedge clk_i)
        rst_i |-> din_w == pad_i)
        else $error("input clamped while reset is held");
    a_wake_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        wake_i && !(lane0_w && hit_slp_w) |=> !asleep_r)
        else $error("wake did not clear the asleep bit");
    a_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        s_write_lane0(PPS_ADR_EXT_FLAG) ##0 set_w == 8'h00 |=>
        (flag_r & $past(wbyte_w)) == 8'h00)
        else $error("writing one to a flag did not clear it");
endmodule
`default_nettype wire

/* File: verif/pps_pad_board.sv */
// Purpose: Board model for the port pads: resolves block drive, external source and pull-up.
// Assumes: The external source only acts where the block does not drive the pin.
// Notes:   A floating pin toggles every cycle so that no stale level can be read back.
`default_nettype none
module pps_pad_board
    import pps_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic [PPS_WIDTH-1:0] pad_o_i,
    input  wire logic [PPS_WIDTH-1:0] pad_oe_i,
    input  wire logic [PPS_WIDTH-1:0] pullup_en_i,
    input  wire logic [PPS_WIDTH-1:0] ext_en_i,
    input  wire logic [PPS_WIDTH-1:0] ext_val_i,
    output logic      [PPS_WIDTH-1:0] pad_lvl_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [PPS_WIDTH-1:0] float_r = '0;
    always @(posedge clk_i)
    begin
        float_r <= ~float_r;
    end
    // Block drive wins, then the external source, then the pull-up, else the pin floats.
    assign pad_lvl_o = (pad_oe_i & pad_o_i) | (~pad_oe_i & ext_en_i & ext_val_i)
                     | (~pad_oe_i & ~ext_en_i & pullup_en_i)
                     | (~pad_oe_i & ~ext_en_i & ~pullup_en_i & float_r);
endmodule
`default_nettype wire

/* File: verif/pps_port_pin_control_tb.sv */
// Purpose: Self-checking bench for the port pin control block.
// Assumes: Wishbone answers come one cycle after capture; the bench still waits on ack.
// Notes:   Pads are resolved by the board model; ext_en_r lets the bench source pins.
`default_nettype none
module pps_port_pin_control_tb
    import pps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i, rst_i, cyc, stb, we, ack, wake;
    logic [7:0]  adr, oe, po, pu, flags, pad, ext_en_r, ext_val_r;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat;
    int          errors, total_checks;
    pps_sleep_mode_type modes [3] = '{PPS_SLEEP_POWER_DOWN, PPS_SLEEP_POWER_SAVE,
                                     PPS_SLEEP_STANDBY};

    pps_port_pin_control dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .pad_i(pad), .pad_o(po), .pad_oe_o(oe), .pullup_en_o(pu),
        .wake_i(wake), .ext_flag_o(flags));
    pps_pad_board board_u (.clk_i(clk_i), .pad_o_i(po), .pad_oe_i(oe), .pullup_en_i(pu),
        .ext_en_i(ext_en_r), .ext_val_i(ext_val_r), .pad_lvl_o(pad));

    always #5 clk_i = ~clk_i;

    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d,
                            output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= 4'h3;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        if (n >= 50)
        begin
            chk("ack", 32'h1, 32'h0);
            conclude;
        end
    endtask

    task automatic wb_wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb_cycle(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb_cycle(1'b0, a, 32'h0, q);
        chk(name, e, q);
    endtask

    task automatic t_reset_values;
        logic [7:0] adrs [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
        foreach (adrs[i])
            rd_chk("reset_reg", adrs[i], 32'h0);
        chk("reset_oe", 32'h0, {24'h0, oe});
        $display("test reset_values done");
    endtask

    task automatic t_pin_states;
        logic [7:0] d, v;
        for (int c = 0; c < 4; c++)
        begin
            d = {8{c[1]}};
            v = {8{c[0]}};
            wb_wr(PPS_ADR_DIRECTION, {24'h0, d});
            wb_wr(PPS_ADR_DRIVE, {24'h0, v});
            @(posedge clk_i);
            #1;
            chk("oe", {24'h0, d}, {24'h0, oe});
            chk("pad_o", {24'h0, d & v}, {24'h0, oe & po});
            chk("pullup", {24'h0, ~d & v}, {24'h0, pu});
        end
        wb_wr(PPS_ADR_DIRECTION, 32'h0);
        wb_wr(PPS_ADR_MCU_CONTROL, 32'h10);
        rd_chk("ctrl", PPS_ADR_MCU_CONTROL, 32'h10);
        chk("pullup_off", 32'h0, {24'h0, pu});
        wb_wr(PPS_ADR_MCU_CONTROL, 32'h0);
        #1;
        chk("pullup_on", 32'hff, {24'h0, pu});
        $display("test pin_states done");
    endtask

    task automatic t_reset_midrun;
        wb_wr(PPS_ADR_DIRECTION, 32'h0f);
        @(posedge clk_i);
        rst_i <= 1'b1;
        #1;
        chk("rst_oe", 32'h0, {24'h0, oe});
        chk("rst_pullup", 32'h0, {24'h0, pu});
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        $display("test reset_midrun done");
    endtask

    task automatic t_loopback;
        wb_wr(PPS_ADR_DIRECTION, 32'hff);
        wb_wr(PPS_ADR_DRIVE, 32'ha5);
        rd_chk("loop_sample", PPS_ADR_INPUT_SAMPLE, 32'ha5);
        wb_wr(PPS_ADR_DIRECTION, 32'h0);
        ext_val_r <= 8'h3c;
        rd_chk("ext_sample", PPS_ADR_INPUT_SAMPLE, 32'h3c);
        wb_wr(PPS_ADR_INPUT_SAMPLE, 32'h0f);
        rd_chk("toggle", PPS_ADR_DRIVE, 32'haa);
        wb_wr(PPS_ADR_INPUT_SAMPLE, 32'h0);
        rd_chk("no_toggle", PPS_ADR_DRIVE, 32'haa);
        $display("test loopback done");
    endtask

    task automatic t_sleep_clamp;
        wb_wr(PPS_ADR_DRIVE, 32'h0);
        ext_val_r <= 8'hff;
        wb_wr(PPS_ADR_EXT_SENSE, 32'h0d);
        wb_wr(PPS_ADR_EXT_ENABLE, 32'h02);
        wb_wr(PPS_ADR_SLEEP_CONTROL, 32'h80);
        rd_chk("idle_sample", PPS_ADR_INPUT_SAMPLE, 32'hff);
        foreach (modes[i])
        begin
            wb_wr(PPS_ADR_SLEEP_CONTROL, 32'h80 | 32'(modes[i]));
            rd_chk("clamp", PPS_ADR_INPUT_SAMPLE, 32'h02);
            wb_wr(PPS_ADR_EXT_FLAG, 32'hff);
            @(posedge clk_i);
            wake <= 1'b1;
            @(posedge clk_i);
            wake <= 1'b0;
            repeat (4) @(posedge clk_i);
            chk("wake_flag", 32'h01, {24'h0, flags});
            rd_chk("awake", PPS_ADR_SLEEP_CONTROL, 32'(modes[i]));
            wb_wr(PPS_ADR_EXT_FLAG, 32'hff);
        end
        $display("test sleep_clamp done");
    endtask

    initial
    begin
        clk_i = 1'b0; rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; wake = 1'b0;
        adr = 8'h0; sel = 4'h0; wdat = 32'h0; ext_en_r = 8'hff; ext_val_r = 8'h0;
        errors = 0; total_checks = 0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset_values;
        t_pin_states;
        t_reset_midrun;
        t_reset_values;
        t_loopback;
        t_sleep_clamp;
        conclude;
    end

    initial
    begin
        #200000;
        $display("watchdog expired");
        errors++;
        conclude;
    end
endmodule
`default_nettype wire
